// >>> src/ibcs_defines.vh
// constants for the instruction bus cycle sequencer
// Contract
// - fixed ordered bus cycle list per instruction
// - no bus release after locked cycle
// - prefetch next instruction, except BR16; sole cycle if register-only with no extension words
// - first extension word read at offset two
// - second extension word read at offset four
// - third extension word read at offset six
// - fourth extension word read at offset eight
`ifndef IBCS_DEFINES_VH
`define IBCS_DEFINES_VH
// instruction classes given by the execution unit
`define IBCS_CL_REG 3'h0
`define IBCS_CL_RD 3'h1
`define IBCS_CL_WR 3'h2
`define IBCS_CL_RMW 3'h3
`define IBCS_CL_BR8 3'h4
`define IBCS_CL_BR16 3'h5
// cycle kinds
`define IBCS_K_EXT 3'h0
`define IBCS_K_NEXT 3'h1
`define IBCS_K_EA 3'h2
`define IBCS_K_IDLE 3'h3
`define IBCS_K_END 3'h4
// instruction word size in bytes
`define IBCS_WORD_BYTES 24'h000002
`define IBCS_STEP_W 3
`endif

// >>> src/ibcs_seq.v
// instruction bus cycle sequencer top
`timescale 1ns/1ps
`include "ibcs_defines.vh"
module ibcs_seq #(
   parameter AW = 24
) (
   input wire sys_clk,
   input wire arst_n,
   input wire inst_start,
   input wire [2:0] inst_class,
   input wire [2:0] inst_ext_words,
   input wire [AW-1:0] inst_addr,
   input wire [AW-1:0] inst_ea,
   input wire inst_ea_word,
   output wire inst_ready,
   output reg inst_done_q,
   output reg bus_req_q,
   output reg [AW-1:0] bus_addr_q,
   output reg bus_write_q,
   output reg bus_word_q,
   output reg bus_lock_q,
   output reg bus_rd_n_q,
   output reg upper_byte_write_strobe_n,
   output reg lower_byte_write_strobe_n,
   output reg effective_address_cycle,
   input wire bus_done,
   input wire ext_breq,
   output reg bus_grant_q,
   output reg lock_q
);
   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_ISSUE = 2'h1;
   localparam [1:0] S_BUS = 2'h2;
   reg [1:0] state_q;
   reg [2:0] class_q;
   reg [2:0] ext_q;
   reg [2:0] step_q;
   reg [AW-1:0] base_q;
   reg [AW-1:0] ea_q;
   reg ea_word_q;
   wire [2:0] kind;
   wire d_write;
   wire d_lock;
   wire d_word;
   reg [AW-1:0] addr_d;
   reg word_d;
   wire may_issue;

   // byte offset of instruction word n (0 = opcode word)
   function [AW-1:0] word_off;
      input [2:0] n;
      begin
         word_off = {{(AW-3){1'b0}}, n} * `IBCS_WORD_BYTES;
      end
   endfunction

   ibcs_step_dec u_dec (
      .op_class(class_q),
      .ext_words(ext_q),
      .step(step_q),
      .kind(kind),
      .is_write(d_write),
      .is_lock(d_lock),
      .force_word(d_word)
   );

   // an outside master is kept off while a locked sequence runs
   assign may_issue = lock_q | ~ext_breq;
   assign inst_ready = (state_q == S_IDLE);

   always @* begin
      addr_d = ea_q;
      word_d = d_word | ea_word_q;
      if (kind == `IBCS_K_EXT) begin
         addr_d = base_q + word_off(step_q + 3'h1);
      end else if (kind == `IBCS_K_NEXT) begin
         addr_d = base_q + word_off(ext_q + 3'h1);
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= S_IDLE;
         class_q <= 3'h0;
         ext_q <= 3'h0;
         step_q <= 3'h0;
         base_q <= {AW{1'b0}};
         ea_q <= {AW{1'b0}};
         ea_word_q <= 1'b0;
         inst_done_q <= 1'b0;
         bus_req_q <= 1'b0;
         bus_addr_q <= {AW{1'b0}};
         bus_write_q <= 1'b0;
         bus_word_q <= 1'b0;
         bus_lock_q <= 1'b0;
         bus_rd_n_q <= 1'b1;
         upper_byte_write_strobe_n <= 1'b1;
         lower_byte_write_strobe_n <= 1'b1;
         effective_address_cycle <= 1'b0;
         bus_grant_q <= 1'b0;
         lock_q <= 1'b0;
      end else begin
         inst_done_q <= 1'b0;
         // grant only between cycles and never inside a locked sequence
         bus_grant_q <= ext_breq & ~lock_q & (state_q != S_BUS);
         case (state_q)
            S_IDLE: begin
               if (inst_start) begin
                  class_q <= inst_class;
                  ext_q <= inst_ext_words;
                  base_q <= inst_addr;
                  ea_q <= inst_ea;
                  ea_word_q <= inst_ea_word;
                  step_q <= 3'h0;
                  state_q <= S_ISSUE;
               end
            end
            S_ISSUE: begin
               if (kind == `IBCS_K_END) begin
                  inst_done_q <= 1'b1;
                  state_q <= S_IDLE;
               end else if (kind == `IBCS_K_IDLE) begin
                  step_q <= step_q + 3'h1;
               end else if (may_issue && !bus_grant_q) begin
                  bus_req_q <= 1'b1;
                  bus_addr_q <= addr_d;
                  bus_write_q <= d_write;
                  bus_word_q <= word_d;
                  bus_lock_q <= d_lock;
                  bus_rd_n_q <= d_write;
                  upper_byte_write_strobe_n <= ~(d_write & (word_d | ~addr_d[0]));
                  lower_byte_write_strobe_n <= ~(d_write & (word_d | addr_d[0]));
                  effective_address_cycle <= (kind == `IBCS_K_EA);
                  state_q <= S_BUS;
               end
            end
            S_BUS: begin
               if (bus_done) begin
                  bus_req_q <= 1'b0;
                  bus_rd_n_q <= 1'b1;
                  upper_byte_write_strobe_n <= 1'b1;
                  lower_byte_write_strobe_n <= 1'b1;
                  effective_address_cycle <= 1'b0;
                  // lock follows the cycle just finished; the closing write drops it
                  lock_q <= bus_lock_q;
                  step_q <= step_q + 3'h1;
                  state_q <= S_ISSUE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule // ibcs_seq

// >>> src/ibcs_step_dec.v
// cycle descriptor for one step of an instruction's bus cycle list
`timescale 1ns/1ps
`include "ibcs_defines.vh"
module ibcs_step_dec (
   input wire [2:0] op_class,
   input wire [2:0] ext_words,
   input wire [2:0] step,
   output reg [2:0] kind,
   output reg is_write,
   output reg is_lock,
   output reg force_word
);
   reg [2:0] post;
   always @* begin
      post = step - ext_words;
      kind = `IBCS_K_END;
      is_write = 1'b0;
      is_lock = 1'b0;
      force_word = 1'b1;
      if (step < ext_words) begin
         kind = `IBCS_K_EXT;
      end else begin
         case (op_class)
            `IBCS_CL_REG: begin
               if (post == 3'h0) kind = `IBCS_K_NEXT;
            end
            `IBCS_CL_RD: begin
               if (post == 3'h0) begin
                  kind = `IBCS_K_EA;
                  force_word = 1'b0;
               end else if (post == 3'h1) begin
                  kind = `IBCS_K_NEXT;
               end
            end
            `IBCS_CL_WR: begin
               if (post == 3'h0) begin
                  kind = `IBCS_K_EA;
                  is_write = 1'b1;
                  force_word = 1'b0;
               end else if (post == 3'h1) begin
                  kind = `IBCS_K_NEXT;
               end
            end
            `IBCS_CL_RMW: begin
               if (post == 3'h0) begin
                  kind = `IBCS_K_EA;
                  is_lock = 1'b1;
                  force_word = 1'b0;
               end else if (post == 3'h1) begin
                  kind = `IBCS_K_NEXT;
                  is_lock = 1'b1;
               end else if (post == 3'h2) begin
                  kind = `IBCS_K_EA;
                  is_write = 1'b1;
                  force_word = 1'b0;
               end
            end
            `IBCS_CL_BR8: begin
               if (post == 3'h0) kind = `IBCS_K_NEXT;
               else if (post == 3'h1) kind = `IBCS_K_EA;
            end
            `IBCS_CL_BR16: begin
               if (post == 3'h0) kind = `IBCS_K_IDLE;
               else if (post == 3'h1) kind = `IBCS_K_EA;
            end
            default: kind = `IBCS_K_END;
         endcase
      end
   end
endmodule // ibcs_step_dec

// >>> tb/ibcs_bus_model.sv
// bus interface model ending each cycle after a short wait
`timescale 1ns/1ps
module ibcs_bus_model (
   input wire sys_clk,
   input wire arst_n,
   input wire bus_req_q,
   input wire [1:0] wait_max,
   output reg done_q
);
   reg [1:0] cnt_q;
   // done is one cycle only, so a held request never ends two cycles
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         done_q <= 1'h0;
         cnt_q <= 2'h0;
      end else begin
         done_q <= bus_req_q && !done_q && cnt_q == wait_max;
         cnt_q <= (bus_req_q && !done_q && cnt_q != wait_max) ? cnt_q + 2'h1 : 2'h0;
      end
   end
endmodule // ibcs_bus_model

// >>> tb/ibcs_seq_monitor.sv
// checker on the sequencer's bus cycle ports
`timescale 1ns/1ps
module ibcs_seq_monitor #(
   parameter AW = 24
) (
   input wire sys_clk,
   input wire arst_n,
   input wire inst_start,
   input wire inst_ready,
   input wire [2:0] inst_class,
   input wire [2:0] inst_ext_words,
   input wire ext_breq,
   input wire bus_req_q,
   input wire bus_done,
   input wire [AW-1:0] bus_addr_q,
   input wire bus_write_q,
   input wire bus_word_q,
   input wire bus_lock_q,
   input wire bus_rd_n_q,
   input wire upper_byte_write_strobe_n,
   input wire lower_byte_write_strobe_n,
   input wire bus_grant_q,
   input wire lock_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   a_addr_hold: assert property (bus_req_q && !bus_done |=> bus_req_q && $stable(bus_addr_q)) else $error("addr moved");
   a_req_drop: assert property (bus_req_q && bus_done |=> !bus_req_q) else $error("req held");
   a_read_level: assert property (bus_req_q |-> bus_rd_n_q == bus_write_q) else $error("rd level");
   a_strobe_lanes: assert property (bus_req_q && bus_write_q |-> {upper_byte_write_strobe_n,
      lower_byte_write_strobe_n} == (bus_word_q ? 2'h0 : {bus_addr_q[0], !bus_addr_q[0]})) else $error("lanes");
   a_lock_set: assert property (bus_req_q && bus_done && bus_lock_q |=> lock_q) else $error("lock");
   a_lock_grant: assert property (lock_q |-> !bus_grant_q) else $error("grant in lock");
   a_grant_idle: assert property (bus_grant_q |-> !bus_req_q) else $error("grant in cycle");
   a_hold_off: assert property (((ext_breq && !lock_q) || bus_grant_q) && !bus_req_q |=> !bus_req_q)
      else $error("issued while bus wanted");
   // a pending request may delay the first cycle, so only quiet starts count; only a bare write starts writing
   a_first_fetch: assert property (inst_start && inst_ready && inst_class < 3'h5 && !bus_grant_q && !ext_breq
      ##1 !ext_breq |=> bus_req_q && bus_write_q == ($past(inst_class, 2) == 3'h2 && $past(inst_ext_words, 2) == 3'h0))
      else $error("no fetch");
endmodule // ibcs_seq_monitor
bind ibcs_seq ibcs_seq_monitor #(.AW(AW)) mon (.*);

// >>> tb/ibcs_seq_tb_top.sv
// self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
module ibcs_seq_tb_top;
   reg sys_clk = 0, arst_n = 0, inst_start = 0, inst_ea_word = 0, ext_breq = 0;
   reg [2:0] inst_class = 0, inst_ext_words = 0;
   reg [23:0] inst_addr = 0, inst_ea = 0;
   reg [31:0] seed = 32'hFA9AE903;
   integer errors = 0, total_checks = 0, n, c, x;
   wire inst_done_q, bus_req_q, bus_write_q, bus_word_q, bus_lock_q, bus_done, lock_q, eac, rdy;
   wire [23:0] bus_addr_q;
   reg [27:0] exp_q[$];
   reg [1:0] wt = 0;
   always #2 sys_clk = ~sys_clk;
   // a request that arrives while locked must wait for the closing write; stray ones test the hold-off
   always @(posedge sys_clk) ext_breq <= lock_q | (($random(seed) & 7) == 0);
   ibcs_seq uut (.sys_clk(sys_clk), .arst_n(arst_n), .inst_start(inst_start), .inst_class(inst_class),
      .inst_ext_words(inst_ext_words), .inst_addr(inst_addr), .inst_ea(inst_ea), .inst_ea_word(inst_ea_word),
      .inst_ready(rdy), .inst_done_q(inst_done_q), .bus_req_q(bus_req_q), .bus_addr_q(bus_addr_q),
      .bus_write_q(bus_write_q), .bus_word_q(bus_word_q), .bus_lock_q(bus_lock_q), .bus_rd_n_q(),
      .upper_byte_write_strobe_n(), .lower_byte_write_strobe_n(), .effective_address_cycle(eac),
      .bus_done(bus_done), .ext_breq(ext_breq), .bus_grant_q(), .lock_q(lock_q));
   ibcs_bus_model bus (.sys_clk(sys_clk), .arst_n(arst_n), .bus_req_q(bus_req_q), .wait_max(wt),
      .done_q(bus_done));
   task chk(input string what, input [27:0] e, input [27:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", what, e, g);
      end
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task p(input [3:0] f, input [23:0] ad);
      exp_q.push_back({f, ad});
   endtask
   always @(posedge sys_clk) if (bus_req_q && bus_done)
      chk("cycle", exp_q.size() ? exp_q.pop_front() : 28'hX,
         {eac, bus_lock_q, bus_write_q, bus_word_q, bus_addr_q});
   task run(input [2:0] cl, input [2:0] xw);
      reg [23:0] a, e, nx;
      reg w;
      integer i;
      a = $random(seed) & 24'hFFFFF0;
      e = $random(seed);
      w = cl > 3 || seed[3];
      e[0] = e[0] & !w;
      wt = seed[1:0];
      nx = a + 24'(2 * xw + 2);
      for (i = 1; i <= xw; i++) p(4'h1, a + 24'(2 * i));
      case (cl)
         0: p(4'h1, nx);
         1, 2: begin
            p({2'h2, cl == 2, w}, e);
            p(4'h1, nx);
         end
         3: begin
            p({3'h6, w}, e);
            p(4'h5, nx);
            p({3'h5, w}, e);
         end
         4: begin
            p(4'h1, nx);
            p(4'h9, e);
         end
         default: p(4'h9, e);
      endcase
      @(posedge sys_clk);
      inst_start <= 1;
      inst_class <= cl;
      inst_ext_words <= xw;
      inst_addr <= a;
      inst_ea <= e;
      inst_ea_word <= w;
      @(posedge sys_clk);
      inst_start <= 0;
      n = 0;
      while (inst_done_q !== 1'b1 && n < 300) begin
         @(negedge sys_clk);
         n++;
      end
      chk("finish", 28'h1, inst_done_q);
      chk("ready", 28'h1, rdy);
      chk("leftover", 28'h0, exp_q.size());
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      arst_n <= 1;
      for (c = 0; c < 4; c++)
         for (x = 0; x < 5; x++) run(c, x);
      run(4, 0);
      run(5, 1);
      wrap_up;
   end
   initial begin
      #20000;
      errors++;
      wrap_up;
   end
endmodule // ibcs_seq_tb_top
